/* hw/slot_pkg.sv */
// Purpose: Shared constants and types for the slot control register block
// Assumes: APB with 32-bit data, byte addresses
// Notes: Control and status share one aligned word
package slot_pkg;

  // Register byte addresses
  localparam logic [11:0] cap_addr = 12'h054;
  localparam logic [11:0] ctl_addr = 12'h058;
  localparam logic [11:0] mask_addr = 12'h05c;

  // Control field positions
  localparam int button_pos = 0;
  localparam int fault_pos = 1;
  localparam int latch_pos = 2;
  localparam int presence_pos = 3;
  localparam int cmd_done_pos = 4;
  localparam int master_pos = 5;
  localparam int attn_lo = 6;
  localparam int pwr_lo = 8;
  localparam int power_pos = 10;
  localparam int interlock_pos = 11;
  localparam int link_pos = 12;

  // Status field positions (upper half of the control word)
  localparam int status_shift = 16;
  localparam int link_chg_pos = 8;

  // Capability field positions
  localparam int cap_button = 0;
  localparam int cap_power_ctl = 1;
  localparam int cap_latch = 2;
  localparam int cap_attn_lamp = 3;
  localparam int cap_pwr_lamp = 4;
  localparam int cap_hp_capable = 6;
  localparam int cap_interlock = 17;

  // Writable capability bits
  localparam logic [31:0] cap_wmask = 32'h0002_007f;
  // Status bits that exist; event-sourced, write one to clear
  localparam logic [15:0] status_wmask = 16'h011f;

  // Reset values
  localparam logic [1:0] lamp_off = 2'h3;
  localparam logic [1:0] lamp_on = 2'h1;
  localparam logic [1:0] attn_reset = lamp_off;
  localparam logic [1:0] pwr_reset = lamp_on;
  localparam logic power_reset = 1'b0;
  localparam logic [31:0] cap_reset = 32'h0000_0000;
  localparam logic [15:0] mask_reset = 16'h0000;

  // Lamp and power state carried to the slot
  typedef struct packed {
    logic [1:0] attn_lamp;
    logic [1:0] pwr_lamp;
    logic slot_power_off;
  } slot_drive_s;

  // Per-event notification enables
  typedef struct packed {
    logic link_chg;
    logic cmd_done;
    logic presence;
    logic latch;
    logic fault;
    logic button;
  } notify_en_s;

endpackage : slot_pkg

/* hw/slot_cmd_tracker.sv */
// Purpose: Tracks one slot command until its expander transfer ends
// Assumes: Expander logic runs on pclk and answers with a done pulse
// Notes: A command arriving while busy is queued once
`timescale 1ns/1ps
module slot_cmd_tracker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command side
  input wire logic start,
  input wire slot_pkg::slot_drive_s drive_in,
  output logic cmd_done,
  output logic busy,
  // Expander side
  output logic exp_req,
  output slot_pkg::slot_drive_s exp_data,
  input wire logic exp_done
);
  import slot_pkg::*;

  typedef enum logic [0:0] {idle, wait_xfer} state_e;

  state_e state;
  logic pending;

  assign busy = (state != idle) || pending;
  assign exp_req = (state == wait_xfer);

  // Transfer sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= idle;
    end else begin
      case (state)
        idle: begin
          if (start || pending) begin
            state <= wait_xfer;
          end
        end
        wait_xfer: begin
          if (exp_done) begin
            state <= idle;
          end
        end
        default: state <= idle;
      endcase
    end
  end

  // Data handed to the expander, captured at launch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_data <= '0;
    end else if (state == idle && (start || pending)) begin
      exp_data <= drive_in;
    end
  end

  // Queue a command that arrives while a transfer runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
    end else if (start && state == wait_xfer) begin
      pending <= 1'b1;
    end else if (state == idle) begin
      pending <= 1'b0;
    end
  end

  // Done only once every queued write has been transferred
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= (state == wait_xfer) && exp_done && !pending && !start; // R17
    end
  end

endmodule : slot_cmd_tracker

/* hw/slot_control_regs.sv */
// Purpose: Slot control register with status, mask and interrupt over APB
// Assumes: Event inputs are one-cycle pulses from logic on pclk
// Notes: Zero wait states; unmapped addresses answer with pslverr
//
// Behaviour
// [R1] Button notify enable lets button presses interrupt or wake; resets zero.
// [R2] Power fault notify enable lets power faults interrupt or wake.
// [R3] Latch sensor notify enable lets latch changes interrupt or wake.
// [R4] Presence notify enable lets presence changes interrupt or wake; always writable.
// [R5] Command done enable lets command completion interrupt; never wakes.
// [R6] Master enable gates every hot-plug interrupt.
// [R7] Fields read zero and ignore writes when their capability is absent.
// [R8] Attention lamp field drives the lamp, reads back; resets to off.
// [R9] Attention lamp field reads zero without attention lamp capability.
// [R10] Power lamp field drives the lamp, reads back; resets to on.
// [R11] Power lamp field reads zero without power lamp capability.
// [R12] On the upstream port power lamp writes do not reach the lamp.
// [R13] Slot power bit sets power, reads back; zero is on; resets zero.
// [R14] Interlock toggle bit always reads zero.
// [R15] Writing one toggles an existing interlock; zero leaves it alone.
// [R16] Link active notify enable lets link changes interrupt or wake; always writable.
// [R17] One control write is one command; done after all transfers finish.
// [R18] Bits 15:13 read zero; interrupt needs master, enable and status set.
`timescale 1ns/1ps
module slot_control_regs #(
  parameter int addr_width = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port role
  input wire logic upstream_port,
  // Slot events
  input wire logic button_pressed,
  input wire logic power_fault,
  input wire logic latch_changed,
  input wire logic presence_changed,
  input wire logic link_active_changed,
  // Slot drive
  output slot_pkg::slot_drive_s slot_drive,
  output logic interlock_toggle_pulse,
  output logic interlock_engaged,
  // Expander handshake
  output logic exp_req,
  output slot_pkg::slot_drive_s exp_data,
  input wire logic exp_done,
  // Notification
  output logic hp_irq,
  output logic wake_event,
  output logic cmd_busy
);
  import slot_pkg::*;

  // Address width the decode can serve
  if (addr_width < 12 || addr_width > 32) begin : g_width_check
    $error("addr_width must be 12 to 32");
  end

  // Register state
  logic [31:0] cap;
  logic [15:0] status;
  logic [15:0] mask;
  notify_en_s notify;
  logic master_en;
  logic [1:0] attn_lamp;
  logic [1:0] pwr_lamp;
  logic slot_power_off;
  logic cmd_done;

  // Bus decode
  logic wr_en;
  logic rd_en;
  logic hit_cap;
  logic hit_ctl;
  logic hit_mask;
  logic ctl_lo_wr;
  logic ctl_hi_wr;
  logic ctl_cmd;
  logic [15:0] ctl_read;
  logic [15:0] status_set;
  logic [15:0] status_clr;
  logic [15:0] en_vec;
  logic [31:0] next_prdata;
  logic attn_wr;
  logic pwr_wr;
  logic power_wr;
  logic toggle_wr;
  slot_drive_s next_slot_drive;

  // Byte-lane write merge
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : lane_merge

  function automatic logic addr_hit(input logic [addr_width-1:0] a, input logic [11:0] reg_addr);
    return (a[addr_width-1:2] == (addr_width-2)'(reg_addr[11:2]));
  endfunction : addr_hit

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign hit_cap = addr_hit(paddr, cap_addr);
  assign hit_ctl = addr_hit(paddr, ctl_addr);
  assign hit_mask = addr_hit(paddr, mask_addr);
  assign ctl_lo_wr = wr_en && hit_ctl && pstrb[0];
  assign ctl_hi_wr = wr_en && hit_ctl && pstrb[1];
  assign ctl_cmd = ctl_lo_wr || ctl_hi_wr; // R17

  // Field write strobes, capability gated
  assign attn_wr = ctl_lo_wr && cap[cap_attn_lamp];
  assign pwr_wr = ctl_hi_wr && cap[cap_pwr_lamp] && !upstream_port; // R12
  assign power_wr = ctl_hi_wr && cap[cap_power_ctl];
  assign toggle_wr = ctl_hi_wr && cap[cap_interlock] && pwdata[interlock_pos]; // R15

  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_cap || hit_ctl || hit_mask);

  // Capabilities
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= cap_reset;
    end else if (wr_en && hit_cap) begin
      cap <= lane_merge(cap, pwdata, pstrb) & cap_wmask;
    end
  end

  // Notification enables, low lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notify.button <= 1'b0; // R1
      notify.fault <= 1'b0;
      notify.latch <= 1'b0;
      notify.presence <= 1'b0;
      notify.cmd_done <= 1'b0;
      master_en <= 1'b0;
    end else if (ctl_lo_wr) begin
      if (cap[cap_button]) begin
        notify.button <= pwdata[button_pos]; // R1 R7
      end
      if (cap[cap_power_ctl]) begin
        notify.fault <= pwdata[fault_pos]; // R2 R7
      end
      if (cap[cap_latch]) begin
        notify.latch <= pwdata[latch_pos]; // R3 R7
      end
      notify.presence <= pwdata[presence_pos]; // R4
      if (cap[cap_hp_capable]) begin
        notify.cmd_done <= pwdata[cmd_done_pos]; // R5 R7
        master_en <= pwdata[master_pos]; // R6 R7
      end
    end
  end

  // Link active notify enable, high lane
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      notify.link_chg <= 1'b0;
    end else if (ctl_hi_wr) begin
      notify.link_chg <= pwdata[link_pos]; // R16
    end
  end

  // Attention lamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attn_lamp <= attn_reset; // R8
    end else if (attn_wr) begin
      attn_lamp <= pwdata[attn_lo +: 2]; // R8 R7
    end
  end

  // Power lamp; an upstream port never moves it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_lamp <= pwr_reset; // R10
    end else if (pwr_wr) begin
      pwr_lamp <= pwdata[pwr_lo +: 2]; // R10 R12
    end
  end

  // Slot power
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_power_off <= power_reset; // R13
    end else if (power_wr) begin
      slot_power_off <= pwdata[power_pos]; // R13 R7
    end
  end

  // Interlock toggle, not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interlock_toggle_pulse <= 1'b0;
      interlock_engaged <= 1'b0;
    end else begin
      interlock_toggle_pulse <= toggle_wr; // R15
      if (toggle_wr) begin
        interlock_engaged <= !interlock_engaged; // R15
      end
    end
  end

  assign slot_drive.attn_lamp = attn_lamp;
  assign slot_drive.pwr_lamp = pwr_lamp;
  assign slot_drive.slot_power_off = slot_power_off;

  // Command completion tracking
  slot_cmd_tracker u_tracker (
    .pclk(pclk),
    .presetn(presetn),
    .start(ctl_cmd),
    .drive_in(next_slot_drive),
    .cmd_done(cmd_done),
    .busy(cmd_busy),
    .exp_req(exp_req),
    .exp_data(exp_data),
    .exp_done(exp_done)
  );

  // Drive state as it stands after the current write
  function automatic slot_drive_s next_drive();
    slot_drive_s d;
    d.attn_lamp = attn_wr ? pwdata[attn_lo +: 2] : attn_lamp;
    d.pwr_lamp = pwr_wr ? pwdata[pwr_lo +: 2] : pwr_lamp;
    d.slot_power_off = power_wr ? pwdata[power_pos] : slot_power_off;
    return d;
  endfunction : next_drive

  // Drive values handed to the tracker
  always_comb begin
    next_slot_drive = next_drive();
  end

  // Status events
  always_comb begin
    status_set = '0;
    status_set[button_pos] = button_pressed;
    status_set[fault_pos] = power_fault;
    status_set[latch_pos] = latch_changed;
    status_set[presence_pos] = presence_changed;
    status_set[cmd_done_pos] = cmd_done; // R17
    status_set[link_chg_pos] = link_active_changed;
  end

  assign status_clr = (wr_en && hit_ctl) ?
    ({{8{pstrb[3]}}, {8{pstrb[2]}}} & pwdata[status_shift +: 16]) : 16'h0000;

  // Sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= ((status & ~status_clr) | status_set) & status_wmask;
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= mask_reset;
    end else if (wr_en && hit_mask) begin
      mask <= 16'(lane_merge({16'h0000, mask}, pwdata, pstrb)) & status_wmask;
    end
  end

  // Enables laid out like status
  always_comb begin
    en_vec = '0;
    en_vec[button_pos] = notify.button && cap[cap_button];
    en_vec[fault_pos] = notify.fault && cap[cap_power_ctl];
    en_vec[latch_pos] = notify.latch && cap[cap_latch];
    en_vec[presence_pos] = notify.presence;
    en_vec[cmd_done_pos] = notify.cmd_done && cap[cap_hp_capable];
    en_vec[link_chg_pos] = notify.link_chg;
  end

  // Interrupt and wake outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_irq <= 1'b0;
      wake_event <= 1'b0;
    end else begin
      hp_irq <= master_en && cap[cap_hp_capable] && |(status & en_vec & mask); // R6 R18 R1 R2 R3 R4 R5 R16
      wake_event <= |(status & en_vec & ~(16'h0001 << cmd_done_pos)); // R5
    end
  end

  // Control read view
  always_comb begin
    ctl_read = '0; // R18 R14
    ctl_read[button_pos] = notify.button && cap[cap_button]; // R7
    ctl_read[fault_pos] = notify.fault && cap[cap_power_ctl];
    ctl_read[latch_pos] = notify.latch && cap[cap_latch];
    ctl_read[presence_pos] = notify.presence;
    ctl_read[cmd_done_pos] = notify.cmd_done && cap[cap_hp_capable];
    ctl_read[master_pos] = master_en && cap[cap_hp_capable];
    ctl_read[attn_lo +: 2] = cap[cap_attn_lamp] ? attn_lamp : 2'h0; // R9
    ctl_read[pwr_lo +: 2] = cap[cap_pwr_lamp] ? pwr_lamp : 2'h0; // R11
    ctl_read[power_pos] = slot_power_off && cap[cap_power_ctl]; // R13
    ctl_read[link_pos] = notify.link_chg;
  end

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_cap) begin
      next_prdata = cap;
    end else if (hit_ctl) begin
      next_prdata = {status, ctl_read};
    end else if (hit_mask) begin
      next_prdata = {16'h0000, mask};
    end
  end

  // Read data registered in setup, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en && !penable) begin
      prdata <= next_prdata;
    end
  end

endmodule : slot_control_regs

/* dv/slot_ctl_properties.sv */
// Purpose: Port assertions for the slot control register
// Assumes: One pclk domain
// Notes: Bound from the bench top
`timescale 1ns/1ps
module slot_ctl_properties #(
  parameter int addr_width = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic upstream_port,
  // Slot side
  input wire slot_pkg::slot_drive_s slot_drive,
  input wire logic interlock_toggle_pulse,
  input wire slot_pkg::slot_drive_s exp_data,
  input wire logic exp_req,
  input wire logic exp_done,
  input wire logic hp_irq,
  input wire logic cmd_busy
);
  import slot_pkg::*;
  logic acc;
  logic hit;
  logic wr_ctl;
  logic mapped;
  assign acc = psel && penable;
  assign hit = paddr[11:2] == ctl_addr[11:2];
  assign wr_ctl = acc && pwrite && hit;
  assign mapped = hit || paddr[11:2] == cap_addr[11:2] || paddr[11:2] == mask_addr[11:2];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  rsvd_zero_a: assert property (
    acc && !pwrite && hit |-> prdata[15:13] == 3'h0 && !prdata[11])
    else $error("reserved bits read nonzero");
  bad_addr_a: assert property (
    acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  cmd_launch_a: assert property (
    wr_ctl && |pstrb[1:0] && !cmd_busy |=> exp_req)
    else $error("command not launched");
  cmd_hold_a: assert property (
    exp_req && !exp_done |=> exp_req && $stable(exp_data))
    else $error("transfer dropped early");
  cmd_end_a: assert property (
    exp_req && exp_done |=> !exp_req)
    else $error("transfer held after done");
  drive_reset_a: assert property (
    $rose(presetn) |-> slot_drive == {attn_reset, pwr_reset, power_reset})
    else $error("slot drive reset value wrong");
  attn_src_a: assert property (
    $changed(slot_drive.attn_lamp) |-> $past(wr_ctl && pstrb[0]))
    else $error("attention lamp moved without write");
  pwr_src_a: assert property (
    $changed(slot_drive.pwr_lamp) |-> $past(wr_ctl && pstrb[1] && !upstream_port))
    else $error("power lamp moved without write");
  toggle_src_a: assert property (
    interlock_toggle_pulse |-> $past(wr_ctl && pstrb[1] && pwdata[11]))
    else $error("interlock toggled without write of one");
  cover property (wr_ctl ##1 exp_req);
  cover property (hp_irq);
  cover property (acc && pslverr);
  cover property (interlock_toggle_pulse);
endmodule : slot_ctl_properties

/* dv/exp_model.sv */
// Purpose: Expander responder for slot commands
// Assumes: Request level held until done pulse
// Notes: lat sets answer delay in cycles
`timescale 1ns/1ps
module exp_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Handshake
  input wire logic exp_req,
  input wire logic [7:0] lat,
  output logic exp_done
);
  logic [7:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      exp_done <= 1'b0;
    end else if (exp_req && !exp_done && cnt >= lat) begin
      cnt <= 8'h00;
      exp_done <= 1'b1;
    end else begin
      cnt <= (exp_req && !exp_done) ? cnt + 8'h01 : 8'h00;
      exp_done <= 1'b0;
    end
  end
endmodule : exp_model

/* dv/tb_hotplug_slot_control_register.sv */
// Purpose: Directed bench for the slot control register
// Assumes: Expander answered by exp_model
// Notes: One task per scenario
`timescale 1ns/1ps
module tb_hotplug_slot_control_register;
  import slot_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, upstream_port = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'h0;
  logic [4:0] ev = 5'h00;
  logic [7:0] lat = 8'h01;
  logic pready, pslverr, e, interlock_toggle_pulse, interlock_engaged;
  logic exp_req, exp_done, hp_irq, wake_event, cmd_busy;
  slot_drive_s slot_drive, exp_data;
  int errors = 0, n_compared = 0, cyc = 0;
  slot_control_regs #(.addr_width(12)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .upstream_port,
    .button_pressed(ev[0]), .power_fault(ev[1]), .latch_changed(ev[2]),
    .presence_changed(ev[3]), .link_active_changed(ev[4]), .slot_drive,
    .interlock_toggle_pulse, .interlock_engaged, .exp_req, .exp_data, .exp_done,
    .hp_irq, .wake_event, .cmd_busy);
  exp_model xm_u (.pclk, .presetn, .exp_req, .lat, .exp_done);
  always #5 pclk = ~pclk;
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, s);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] want,
      input logic [31:0] m = 32'hffff_ffff);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(r & m, want);
  endtask : rdc
  task automatic wdone();
    do begin
      @(posedge pclk);
    end while (cmd_busy !== 1'b0);
    repeat (3) @(posedge pclk);
  endtask : wdone
  task automatic fire(input int i);
    @(posedge pclk);
    ev <= 5'h01 << i;
    @(posedge pclk);
    ev <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask : fire
  task automatic irqchk(input logic [1:0] want);
    chk({30'h0, hp_irq, wake_event}, {30'h0, want});
  endtask : irqchk
  task automatic t_reset();
    rdc(ctl_addr, 32'h0);
    rdc(mask_addr, 32'h0);
    chk({27'h0, slot_drive}, {27'h0, attn_reset, pwr_reset, power_reset});
    $display("done reset");
  endtask : t_reset
  task automatic t_ctl();
    wr(cap_addr, 32'h0002_007f, 4'hf);
    rdc(ctl_addr, 32'h0000_01c0);
    wr(ctl_addr, 32'h0000_ffbf, 4'h3);
    wdone();
    rdc(ctl_addr, 32'h0010_17bf);
    chk({27'h0, slot_drive}, 32'h0000_0017);
    chk({27'h0, exp_data}, 32'h0000_0017);
    chk({31'h0, interlock_engaged}, 32'h1);
    wr(ctl_addr, 32'h0010_17bf, 4'h7);
    wdone();
    chk({31'h0, interlock_engaged}, 32'h1);
    wr(ctl_addr, 32'h0010_0000, 4'h4);
    rdc(ctl_addr, 32'h0000_17bf);
    $display("done ctl");
  endtask : t_ctl
  task automatic t_irq();
    int sp;
    wr(mask_addr, 32'h0000_010f, 4'hf);
    for (int i = 0; i < 5; i++) begin
      sp = (i == 4) ? 8 : i;
      fire(i);
      irqchk(2'h3);
      rdc(ctl_addr, 32'h1 << (16 + sp), 32'hffff_0000);
      wr(ctl_addr, 32'h1 << (16 + sp), 4'hc);
      repeat (2) @(posedge pclk);
      irqchk(2'h0);
    end
    wr(ctl_addr, 32'h0000_17bf, 4'h3);
    wdone();
    irqchk(2'h0);
    wr(mask_addr, 32'h0000_011f, 4'hf);
    repeat (2) @(posedge pclk);
    irqchk(2'h2);
    wr(ctl_addr, 32'h0010_0000, 4'h4);
    fire(0);
    wr(mask_addr, 32'h0000_011e, 4'hf);
    repeat (2) @(posedge pclk);
    irqchk(2'h1);
    wr(ctl_addr, 32'h0000_179f, 4'h3);
    wdone();
    wr(mask_addr, 32'h0000_011f, 4'hf);
    fire(1);
    irqchk(2'h1);
    wr(ctl_addr, 32'h011f_0000, 4'hc);
    repeat (2) @(posedge pclk);
    irqchk(2'h0);
    $display("done irq");
  endtask : t_irq
  task automatic t_cap();
    wr(cap_addr, 32'h0, 4'hf);
    wr(ctl_addr, 32'h0, 4'h3);
    wdone();
    rdc(ctl_addr, 32'h0, 32'hffff);
    wr(ctl_addr, 32'h0000_1008, 4'h3);
    wdone();
    rdc(ctl_addr, 32'h0000_1008, 32'hffff);
    wr(cap_addr, 32'h0002_007f, 4'hf);
    rdc(ctl_addr, 32'h0000_179f, 32'hffff);
    wr(ctl_addr, 32'h011f_0000, 4'hc);
    $display("done cap");
  endtask : t_cap
  task automatic t_up();
    @(posedge pclk);
    upstream_port <= 1'b1;
    wr(ctl_addr, 32'h0000_169f, 4'h3);
    wdone();
    chk({30'h0, slot_drive.pwr_lamp}, 32'h3);
    rdc(ctl_addr, 32'h0000_179f, 32'hffff);
    upstream_port <= 1'b0;
    wr(ctl_addr, 32'h011f_0000, 4'hc);
    $display("done upstream");
  endtask : t_up
  task automatic t_queue();
    lat <= 8'h14;
    wr(ctl_addr, 32'h0000_175f, 4'h3);
    wr(ctl_addr, 32'h0000_17df, 4'h3);
    do begin
      @(posedge pclk);
    end while (exp_done !== 1'b1);
    rdc(ctl_addr, 32'h0, 32'h0010_0000);
    wdone();
    rdc(ctl_addr, 32'h0010_0000, 32'h0010_0000);
    chk({30'h0, exp_data.attn_lamp}, 32'h3);
    lat <= 8'h01;
    rdc(12'h060, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("done queue");
  endtask : t_queue
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ctl();
    t_irq();
    t_cap();
    t_up();
    t_queue();
    conclude();
  end
endmodule : tb_hotplug_slot_control_register
bind slot_control_regs slot_ctl_properties #(.addr_width(addr_width)) chk_u (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr, .upstream_port,
  .slot_drive, .interlock_toggle_pulse, .exp_data, .exp_req, .exp_done, .hp_irq, .cmd_busy);
